/* rmp_pkg.sv */
// shared constants for the radio module parameter register bank
package rmp_pkg;
  // register numbers (six-bit field of the control byte)
  localparam logic [5:0] REG_MODULE_TYPE_ID  = 6'h08;
  localparam logic [5:0] REG_FIRMWARE_VER    = 6'h09;
  localparam logic [5:0] REG_MIN_DATA_LEN    = 6'h0C;
  localparam logic [5:0] REG_DIP_SETTING     = 6'h10;
  localparam logic [5:0] REG_UNLOCK_CODE     = 6'h1F;
  localparam logic [5:0] REG_CHANNEL_SELECT  = 6'h20;
  localparam logic [5:0] REG_CHANNEL_ACK     = 6'h21;
  localparam logic [5:0] REG_WDOG_TIMEOUT    = 6'h26;
  localparam logic [5:0] REG_BCAST_MODE      = 6'h27;
  localparam logic [5:0] REG_SCAN_RESULT     = 6'h28;
  localparam logic [5:0] REG_NETWORK_ID      = 6'h29;
  localparam logic [5:0] REG_TX_ATTEN        = 6'h2E;
  // control / status byte fields
  localparam int CB_ACCESS_BIT = 7;
  localparam int CB_WRITE_BIT  = 6;
  localparam int CB_SCAN_BIT   = 2;
  // fixed values
  localparam logic [15:0] UNLOCK_VALUE     = 16'h1235;
  localparam logic [15:0] MIN_DATA_LEN_VAL = 16'h0098;
  localparam logic [15:0] DIP_MASTER       = 16'h414D;
  localparam logic [15:0] DIP_BCAST_SLAVE  = 16'h4253;
  localparam logic [15:0] DIP_UNKNOWN      = 16'hFFFF;
  localparam logic [7:0]  DIP_SLAVE_LOW    = 8'h53;
  localparam logic [7:0]  ASCII_ZERO       = 8'h30;
  localparam logic [15:0] BCAST_MASTER_VAL = 16'h4342;
  localparam logic [15:0] BCAST_OFF_VAL    = 16'h0000;
  // reset values of the working registers
  localparam logic [15:0] RST_CHANNEL      = 16'h0005;
  localparam logic [15:0] RST_WDOG         = 16'h0014;
  localparam logic [15:0] RST_BCAST        = 16'h0000;
  localparam logic [15:0] RST_NETID        = 16'h0000;
  localparam logic [15:0] RST_ATTEN        = 16'h0000;
  localparam logic [15:0] ATTEN_MASK       = 16'h00F8;
  localparam logic [3:0]  CHANNEL_MAX      = 4'hF;
  // watchdog tick: one step of about 20 ms
  localparam int  CLK_MHZ     = 250;
  localparam int  WDOG_STEP_MS = 20;
  localparam int  WDOG_STEP_CYC = WDOG_STEP_MS * 1000 * CLK_MHZ;
  // dip switch position codes
  typedef enum logic [3:0] {
    RMP_DIP_MASTER = 4'h0,
    RMP_DIP_BCAST  = 4'h8
  } rmp_dip_t;
endpackage

/* rmp_tick.sv */
// divider giving a one-cycle enable pulse every period
`timescale 1ns/10ps
module rmp_tick #(
  parameter int PERIOD = 5000000
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  output logic      tick
);
  logic [31:0] count;

  // free-running count, pulse on wrap
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      count <= 32'h00000000;
      tick  <= 1'b0;
    end else if (count == 32'(PERIOD - 1)) begin
      count <= 32'h00000000;
      tick  <= 1'b1;
    end else begin
      count <= count + 32'h00000001;
      tick  <= 1'b0;
    end
  end
endmodule

/* rmp_watchdog.sv */
// slave traffic watchdog counting steps of about 20 ms
`timescale 1ns/10ps
module rmp_watchdog (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        step,
  input  wire logic        enable,
  input  wire logic [15:0] timeout,
  input  wire logic        traffic,
  output logic             expired
);
  logic [15:0] steps;

  // restart on traffic; a zero timeout never expires
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      steps   <= 16'h0000;
      expired <= 1'b0;
    end else if (!enable || timeout == 16'h0000 || traffic) begin
      steps   <= 16'h0000;
      expired <= 1'b0;
    end else if (step) begin
      if (steps + 16'h0001 >= timeout) begin
        expired <= 1'b1;
      end else begin
        steps <= steps + 16'h0001;
      end
    end
  end
endmodule

/* rmp_regbank.sv */
// parameter register bank reached through control/status byte exchange
// Notes on behaviour
// - read-only fixed module type code
// - read-only ascii firmware version word
// - min data length: out 0, in 24
// - data length bit 7 set, compact option
// - dip reads master, broadcast slave, unknown
// - addressed slave reads ascii digit plus S
// - user writes dropped unless unlock present
// - unlocked writes go to working and nonvolatile
// - restart clears the unlock code word
// - channel accepts only 0 to 15
// - adopted channel copied to acknowledge register
// - watchdog slave only, zero disables it
// - watchdog timeout is value times 20 ms
// - broadcast mode values, ignored by slaves
// - master scan sets one bit per slave
// - network id filters received telegrams
// - attenuation takes effect after restart only
// - bits 7..6 select coarse attenuation
// - bits 5..3 select fine attenuation
// - status echoes control byte, write bit cleared
// - read returns data word, write meaningless
`timescale 1ns/10ps
module rmp_regbank #(
  parameter logic [15:0] MODULE_TYPE_CODE = 16'h00A5, // arbitrary value
  parameter logic [15:0] FIRMWARE_ASCII   = 16'h3141, // arbitrary value
  parameter int          WDOG_STEP        = rmp_pkg::WDOG_STEP_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        ctrl_valid,
  input  wire logic [7:0]  control_byte_one,
  input  wire logic [15:0] data_out_word,
  output logic [7:0]       status_byte_one,
  output logic [15:0]      data_in_word,
  input  wire logic [3:0]  dip_position,
  input  wire logic [15:0] nv_channel,
  input  wire logic [15:0] nv_wdog,
  input  wire logic [15:0] nv_bcast,
  input  wire logic [15:0] nv_atten,
  output logic             nv_write,
  output logic [5:0]       nv_addr,
  output logic [15:0]      nv_data,
  input  wire logic        channel_adopted,
  output logic [3:0]       radio_channel,
  input  wire logic        slave_found,
  input  wire logic [3:0]  slave_found_addr,
  output logic             scan_active,
  input  wire logic        rx_telegram,
  input  wire logic [7:0]  rx_network_id,
  output logic             rx_accept,
  input  wire logic        slave_traffic,
  output logic             comm_error,
  output logic             bcast_master,
  output logic [1:0]       atten_coarse,
  output logic [2:0]       atten_fine
);
  // working copies of the registers
  logic [15:0] unlock_code;
  logic [15:0] channel_sel;
  logic [15:0] channel_ack;
  logic [15:0] wdog_timeout;
  logic [15:0] bcast_mode;
  logic [15:0] scan_result;
  logic [15:0] network_id;
  logic [15:0] tx_atten;
  logic [15:0] dip_value;
  logic        loaded;

  // decoded control byte
  logic        acc;
  logic        wr;
  logic [5:0]  regnum;
  logic        wr_user;
  logic [15:0] store_data;

  // role, scan and timing helpers
  logic        unlocked;
  logic        is_master;
  logic        is_slave;
  logic        scan_hit;
  logic        scan_clear;
  wire  [15:0] found_hit;
  logic        step;
  logic        wd_expired;

  // decode the dip switch position into its ascii readback
  function automatic logic [15:0] dip_code(input logic [3:0] pos);
    if (pos == rmp_pkg::RMP_DIP_MASTER) begin
      return rmp_pkg::DIP_MASTER;
    end else if (pos == rmp_pkg::RMP_DIP_BCAST) begin
      return rmp_pkg::DIP_BCAST_SLAVE;
    end else if (pos >= 4'h1 && pos <= 4'h7) begin
      return {rmp_pkg::ASCII_ZERO | {4'h0, pos},
              rmp_pkg::DIP_SLAVE_LOW};
    end else begin
      return rmp_pkg::DIP_UNKNOWN;
    end
  endfunction

  // is this register one the controller may change
  function automatic logic user_reg(input logic [5:0] r);
    return r == rmp_pkg::REG_CHANNEL_SELECT ||
           r == rmp_pkg::REG_WDOG_TIMEOUT  ||
           r == rmp_pkg::REG_BCAST_MODE    ||
           r == rmp_pkg::REG_NETWORK_ID    ||
           r == rmp_pkg::REG_TX_ATTEN;
  endfunction

  // channel numbers above the last channel are refused
  function automatic logic chan_ok(input logic [15:0] d);
    return d <= {12'h000, rmp_pkg::CHANNEL_MAX};
  endfunction

  // in register mode bit 2 is part of the register number, so the
  // scan request only counts in plain process data cycles
  function automatic logic scan_req(input logic       valid,
                                    input logic [7:0] cb);
    return valid && !cb[rmp_pkg::CB_ACCESS_BIT]
           && cb[rmp_pkg::CB_SCAN_BIT];
  endfunction

  assign acc       = ctrl_valid
                     && control_byte_one[rmp_pkg::CB_ACCESS_BIT];
  assign wr        = control_byte_one[rmp_pkg::CB_WRITE_BIT];
  assign regnum    = control_byte_one[5:0];
  assign unlocked  = unlock_code == rmp_pkg::UNLOCK_VALUE;
  assign dip_value = dip_code(dip_position);
  assign is_master = dip_value == rmp_pkg::DIP_MASTER;
  assign is_slave  = !is_master && dip_value != rmp_pkg::DIP_UNKNOWN;
  assign wr_user   = acc && wr && unlocked;
  assign scan_hit  = is_master
                     && scan_req(ctrl_valid, control_byte_one);
  assign scan_clear = scan_hit && !scan_active;

  // one set line per slave address in the scan map
  for (genvar i = 0; i < 16; i++) begin : g_found
    assign found_hit[i] = scan_active && slave_found
                          && slave_found_addr == 4'(i);
  end

  // storage sees the attenuation mask like the working register; the network id is stored with its upper byte
  always_comb begin
    store_data = data_out_word;
    if (regnum == rmp_pkg::REG_TX_ATTEN) begin
      store_data = data_out_word & rmp_pkg::ATTEN_MASK;
    end
  end

  // code word: always writable, cleared on every restart
  // any value but the unlock code locks the user registers again
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      unlock_code <= 16'h0000;
    end else if (acc && wr && regnum == rmp_pkg::REG_UNLOCK_CODE) begin
      unlock_code <= data_out_word;
    end
  end

  // user registers: all but the network id restored from storage once, then guarded by unlock
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      loaded       <= 1'b0;
      channel_sel  <= rmp_pkg::RST_CHANNEL;
      wdog_timeout <= rmp_pkg::RST_WDOG;
      bcast_mode   <= rmp_pkg::RST_BCAST;
      network_id   <= rmp_pkg::RST_NETID;
      tx_atten     <= rmp_pkg::RST_ATTEN;
    end else if (!loaded) begin
      // stored values are taken after release, never under reset
      loaded       <= 1'b1;
      channel_sel  <= {12'h000, nv_channel[3:0]};
      wdog_timeout <= nv_wdog;
      bcast_mode   <= nv_bcast;
      tx_atten     <= nv_atten & rmp_pkg::ATTEN_MASK;
    end else if (wr_user) begin
      unique case (regnum)
        rmp_pkg::REG_CHANNEL_SELECT: begin
          if (chan_ok(data_out_word)) begin
            channel_sel <= data_out_word;
          end
        end
        // zero is legal here and switches the watchdog off
        rmp_pkg::REG_WDOG_TIMEOUT: wdog_timeout <= data_out_word;
        // kept as written; only the exact code selects broadcast
        rmp_pkg::REG_BCAST_MODE:   bcast_mode <= data_out_word;
        // only eight bits exist, the upper byte reads zero
        rmp_pkg::REG_NETWORK_ID:
          network_id <= {8'h00, data_out_word[7:0]};
        rmp_pkg::REG_TX_ATTEN:
          tx_atten <= data_out_word & rmp_pkg::ATTEN_MASK;
        default: ;
      endcase
    end
  end

  // mirror unlocked user writes into nonvolatile storage
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      nv_write <= 1'b0;
      nv_addr  <= 6'h00;
      nv_data  <= 16'h0000;
    end else begin
      // a refused channel number must not reach storage either
      nv_write <= loaded && wr_user && user_reg(regnum)
                  && (regnum != rmp_pkg::REG_CHANNEL_SELECT
                      || chan_ok(data_out_word));
      // address and data follow every cycle; only the strobe matters
      nv_addr  <= regnum;
      nv_data  <= store_data;
    end
  end

  // radio side picks up the channel; ack follows only on adoption
  // ack lags until the radio reports the switch, which the host polls
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      radio_channel <= 4'h0;
      channel_ack   <= 16'h0000;
    end else begin
      radio_channel <= channel_sel[3:0];
      if (channel_adopted) begin
        channel_ack <= {12'h000, radio_channel};
      end
    end
  end

  // attenuation sampled once after restart, later writes wait
  // later writes reach tx_atten and storage; the outputs stay until restart
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      atten_coarse <= 2'b00;
      atten_fine   <= 3'b000;
    end else if (!loaded) begin
      atten_coarse <= nv_atten[7:6];
      atten_fine   <= nv_atten[5:3];
    end
  end

  // broadcast master only when dip says master
  // the switch sets the role; the register cannot turn a slave
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bcast_master <= 1'b0;
    end else begin
      bcast_master <= is_master
                      && bcast_mode == rmp_pkg::BCAST_MASTER_VAL;
    end
  end

  // scan: request restarts the map, found slaves accumulate
  // clear needs scan_active low and a set needs it high, so never both
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      scan_active <= 1'b0;
      scan_result <= 16'h0000;
    end else begin
      scan_active <= scan_hit;
      if (scan_clear) begin
        scan_result <= 16'h0000;
      end else begin
        scan_result <= scan_result | found_hit;
      end
    end
  end

  // only telegrams from our own network pass
  // the filter uses the working id, so a new id acts at once
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_accept <= 1'b0;
    end else begin
      rx_accept <= rx_telegram
                   && rx_network_id == network_id[7:0];
    end
  end

  // the divider free-runs, so the first step after traffic may come
  // early; the timeout is only good to one step
  rmp_tick #(
    .PERIOD (WDOG_STEP)
  ) u_tick (
    .sys_clk (sys_clk),
    .rst     (rst),
    .tick    (step)
  );

  // watchdog runs only for slave positions of the switch
  rmp_watchdog u_wdog (
    .sys_clk (sys_clk),
    .rst     (rst),
    .step    (step),
    .enable  (is_slave),
    .timeout (wdog_timeout),
    .traffic (slave_traffic),
    .expired (wd_expired)
  );

  // error flag follows the watchdog
  // one more flop keeps the output straight from a register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      comm_error <= 1'b0;
    end else begin
      comm_error <= wd_expired;
    end
  end

  // answer: echo with write bit cleared, read data muxed
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      status_byte_one <= 8'h00;
      data_in_word    <= 16'h0000;
    end else if (acc) begin
      status_byte_one <= {1'b1, 1'b0, regnum};
      // after a write the old word stays; it carries no meaning
      if (!wr) begin
        unique case (regnum)
          rmp_pkg::REG_MODULE_TYPE_ID:
            data_in_word <= MODULE_TYPE_CODE;
          rmp_pkg::REG_FIRMWARE_VER:
            data_in_word <= FIRMWARE_ASCII;
          rmp_pkg::REG_MIN_DATA_LEN:
            data_in_word <= rmp_pkg::MIN_DATA_LEN_VAL;
          rmp_pkg::REG_DIP_SETTING:    data_in_word <= dip_value;
          rmp_pkg::REG_UNLOCK_CODE:    data_in_word <= unlock_code;
          rmp_pkg::REG_CHANNEL_SELECT: data_in_word <= channel_sel;
          rmp_pkg::REG_CHANNEL_ACK:    data_in_word <= channel_ack;
          rmp_pkg::REG_WDOG_TIMEOUT:   data_in_word <= wdog_timeout;
          rmp_pkg::REG_BCAST_MODE:     data_in_word <= bcast_mode;
          rmp_pkg::REG_SCAN_RESULT:    data_in_word <= scan_result;
          rmp_pkg::REG_NETWORK_ID:     data_in_word <= network_id;
          rmp_pkg::REG_TX_ATTEN:       data_in_word <= tx_atten;
          default:                     data_in_word <= 16'h0000;
        endcase
      end
    end else begin
      status_byte_one <= 8'h00; // process data mode, no receipt
    end
  end
endmodule

/* rmp_regbank_assertions.sv */
// checker bound to the parameter register bank ports
`timescale 1ns/10ps
module rmp_regbank_assertions (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        ctrl_valid,
  input wire logic [7:0]  control_byte_one,
  input wire logic [15:0] data_out_word,
  input wire logic [7:0]  status_byte_one,
  input wire logic [15:0] data_in_word,
  input wire logic [3:0]  dip_position,
  input wire logic        nv_write,
  input wire logic [5:0]  nv_addr,
  input wire logic        scan_active,
  input wire logic        rx_accept,
  input wire logic [1:0]  atten_coarse,
  input wire logic [2:0]  atten_fine
);
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic       acc;
  logic       rd;
  logic [5:0] rn;
  // access decode; scan bit only counts outside register mode
  assign acc = ctrl_valid & control_byte_one[7];
  assign rd  = acc & ~control_byte_one[6];
  assign rn  = control_byte_one[5:0];
  chk_status_echo: assert property (
    acc |=> status_byte_one == {2'b10, $past(rn)})
    else $error("status echo wrong");
  chk_status_idle: assert property (
    !acc |=> status_byte_one == 8'h00)
    else $error("status not idle");
  chk_len_word: assert property (
    rd && rn == 6'h0C |=> data_in_word == 16'h0098)
    else $error("data length word wrong");
  chk_dip_master: assert property (
    rd && rn == 6'h10 && dip_position == 4'h0
    |=> data_in_word == 16'h414D)
    else $error("master dip word wrong");
  chk_dip_slave: assert property (
    rd && rn == 6'h10 && dip_position inside {[4'h1:4'h7]}
    |=> data_in_word == {4'h3, $past(dip_position), 8'h53})
    else $error("slave dip word wrong");
  chk_nv_cause: assert property (
    nv_write |-> $past(acc & control_byte_one[6]) && nv_addr == $past(rn))
    else $error("store without write");
  chk_ro_write: assert property (
    acc && control_byte_one[6] && (rn inside {6'h08, 6'h09, 6'h0C,
    6'h10, 6'h21, 6'h28} || rn == 6'h20 && data_out_word > 16'h000F)
    |=> !nv_write)
    else $error("refused write stored");
  chk_atten_hold: assert property (
    !$past(rst) && !$past(rst, 2) |-> $stable({atten_coarse, atten_fine}))
    else $error("attenuation changed in run");
  chk_scan_start: assert property (
    ctrl_valid && control_byte_one[7:2] == 6'h01 && dip_position == 4'h0
    |=> scan_active)
    else $error("scan not started");
  chk_scan_regmode: assert property (
    acc |=> !scan_active)
    else $error("scan started by register access");
  cov_write: cover property (acc && control_byte_one[6]);
  cov_scan: cover property (scan_active);
  cov_rx: cover property (rx_accept);
endmodule
bind rmp_regbank rmp_regbank_assertions u_rmp_regbank_assertions (
  .sys_clk, .rst, .ctrl_valid, .control_byte_one, .data_out_word,
  .status_byte_one, .data_in_word, .dip_position, .nv_write, .nv_addr,
  .scan_active, .rx_accept, .atten_coarse, .atten_fine
);

/* rmp_fb_model.sv */
// fieldbus controller model issuing control byte accesses
`timescale 1ns/10ps
module rmp_fb_model (
  input  wire logic        sys_clk,
  input  wire logic [7:0]  status_byte_one,
  input  wire logic [15:0] data_in_word,
  output logic             ctrl_valid,
  output logic [7:0]       control_byte_one,
  output logic [15:0]      data_out_word
);
  initial begin
    ctrl_valid = 1'b0;
    control_byte_one = 8'h00;
    data_out_word = 16'h0000;
  end
  // one access; idle word is inverted so stale data never matches
  task automatic xfer(input logic w, input logic [5:0] r,
    input logic [15:0] d, output logic [7:0] st, output logic [15:0] v);
    @(negedge sys_clk);
    ctrl_valid <= 1'b1;
    control_byte_one <= {1'b1, w, r};
    data_out_word <= w ? d : ~d;
    @(negedge sys_clk);
    ctrl_valid <= 1'b0;
    control_byte_one <= 8'h00;
    data_out_word <= ~d;
    st = status_byte_one;
    v = data_in_word;
  endtask
  // process image cycles without register access, held n cycles
  task automatic image(input logic [7:0] cb, input int n);
    @(negedge sys_clk);
    ctrl_valid <= 1'b1;
    control_byte_one <= cb;
    repeat (n) @(negedge sys_clk);
    ctrl_valid <= 1'b0;
    control_byte_one <= 8'h00;
  endtask
endmodule

/* rmp_regbank_tb.sv */
// self-checking bench for the parameter register bank
`timescale 1ns/10ps
module rmp_regbank_tb;
  localparam logic [15:0] TYPE_CODE = 16'h00A5; // arbitrary value
  localparam logic [15:0] FW_CODE   = 16'h3141; // arbitrary value
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        ctrl_valid, nv_write, channel_adopted, slave_found;
  logic        scan_active, rx_telegram, rx_accept, slave_traffic;
  logic        comm_error, bcast_master;
  logic [7:0]  control_byte_one, status_byte_one, rx_network_id;
  logic [15:0] data_out_word, data_in_word, nv_data, nvm [0:63];
  logic [15:0] nv_channel, nv_wdog, nv_bcast, nv_atten;
  logic [5:0]  nv_addr;
  logic [3:0]  dip_position, radio_channel, slave_found_addr;
  logic [1:0]  atten_coarse;
  logic [2:0]  atten_fine;
  int          fail_count = 0;
  int          n_tests = 0;
  always #2 sys_clk = ~sys_clk;
  // nonvolatile store; kept across rst so restarts restore it
  always @(posedge sys_clk)
    if (nv_write) nvm[nv_addr] <= nv_data;
  assign nv_channel = nvm[32];
  assign nv_wdog    = nvm[38];
  assign nv_bcast   = nvm[39];
  assign nv_atten   = nvm[46];
  rmp_regbank #(.MODULE_TYPE_CODE(TYPE_CODE), .FIRMWARE_ASCII(FW_CODE),
    .WDOG_STEP(10)) u_rmp_regbank (.sys_clk, .rst, .ctrl_valid,
    .control_byte_one, .data_out_word, .status_byte_one, .data_in_word,
    .dip_position, .nv_channel, .nv_wdog, .nv_bcast, .nv_atten,
    .nv_write, .nv_addr, .nv_data, .channel_adopted, .radio_channel,
    .slave_found, .slave_found_addr, .scan_active, .rx_telegram,
    .rx_network_id, .rx_accept, .slave_traffic, .comm_error,
    .bcast_master, .atten_coarse, .atten_fine);
  rmp_fb_model u_rmp_fb_model (.sys_clk, .status_byte_one,
    .data_in_word, .ctrl_valid, .control_byte_one, .data_out_word);
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // read with masked compare; every access also checks the echo
  task automatic rdc(input logic [5:0] r, input logic [15:0] m, e);
    logic [7:0]  st;
    logic [15:0] v;
    u_rmp_fb_model.xfer(1'b0, r, 16'h0000, st, v);
    check({8'h00, st}, {10'b10, r});
    check(v & m, e);
  endtask
  task automatic wr(input logic [5:0] r, input logic [15:0] d);
    logic [7:0]  st;
    logic [15:0] v;
    u_rmp_fb_model.xfer(1'b1, r, d, st, v);
    check({8'h00, st}, {10'b10, r});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    cyc(8);
    rst <= 1'b0;
    cyc(2);
  endtask
  task automatic t_fixed();
    rdc(6'h08, 16'hFFFF, TYPE_CODE);
    rdc(6'h09, 16'hFFFF, FW_CODE);
    rdc(6'h0C, 16'hFFFF, 16'h0098);
    rdc(6'h3F, 16'hFFFF, 16'h0000);
    $display("test fixed done");
  endtask
  task automatic t_dip();
    logic [15:0] e;
    for (int p = 0; p < 16; p++) begin
      dip_position <= p[3:0];
      e = p == 0 ? 16'h414D : p == 8 ? 16'h4253 : 16'hFFFF;
      if (p > 0 && p < 8) e = {4'h3, p[3:0], 8'h53};
      rdc(6'h10, 16'hFFFF, e);
    end
    $display("test dip done");
  endtask
  task automatic t_lock();
    wr(6'h26, 16'h0033);
    rdc(6'h26, 16'hFFFF, 16'h0014);
    check(nvm[38], 16'h0014);
    wr(6'h1F, 16'h1235);
    rdc(6'h1F, 16'hFFFF, 16'h1235);
    wr(6'h26, 16'h0033);
    cyc(1);
    check(nvm[38], 16'h0033);
    rdc(6'h26, 16'hFFFF, 16'h0033);
    wr(6'h20, 16'h0010);
    cyc(1);
    check(nvm[32], 16'h0005);
    rdc(6'h20, 16'hFFFF, 16'h0005);
    wr(6'h20, 16'h0009);
    rdc(6'h21, 16'hFFFF, 16'h0000);
    @(negedge sys_clk);
    channel_adopted <= 1'b1;
    @(negedge sys_clk);
    channel_adopted <= 1'b0;
    rdc(6'h21, 16'hFFFF, 16'h0009);
    wr(6'h2E, 16'hFFFF);
    cyc(1);
    check(nvm[46], 16'h00F8);
    rdc(6'h2E, 16'hFFFF, 16'h00F8);
    check({11'h0, atten_coarse, atten_fine}, 16'h0000);
    wr(6'h09, 16'h0000);
    rdc(6'h09, 16'hFFFF, FW_CODE);
    $display("test lock done");
  endtask
  task automatic t_restart();
    do_reset();
    rdc(6'h1F, 16'hFFFF, 16'h0000);
    rdc(6'h26, 16'hFFFF, 16'h0033);
    check({12'h0, radio_channel}, 16'h0009);
    check({11'h0, atten_coarse, atten_fine}, 16'h001F);
    rdc(6'h29, 16'hFFFF, 16'h0000);
    $display("test restart done");
  endtask
  task automatic t_scan_net();
    dip_position <= 4'h0;
    wr(6'h1F, 16'h1235);
    wr(6'h27, 16'h4342);
    cyc(2);
    check({15'h0, bcast_master}, 16'h0001);
    // scan request stands in the image while slaves report
    fork
      u_rmp_fb_model.image(8'h04, 8);
      begin
        cyc(2);
        for (int a = 3; a < 6; a += 2) begin
          @(negedge sys_clk);
          slave_found <= 1'b1;
          slave_found_addr <= a[3:0];
          @(negedge sys_clk);
          slave_found <= 1'b0;
        end
      end
    join
    rdc(6'h28, 16'hFFFF, 16'h0028);
    wr(6'h29, 16'h0007);
    for (int k = 7; k < 9; k++) begin
      @(negedge sys_clk);
      rx_telegram <= 1'b1;
      rx_network_id <= k[7:0];
      @(negedge sys_clk);
      rx_telegram <= 1'b0;
      check({15'h0, rx_accept}, {15'h0, k == 7});
    end
    wr(6'h27, 16'h0000);
    cyc(2);
    check({15'h0, bcast_master}, 16'h0000);
    $display("test scan and network done");
  endtask
  task automatic t_wdog();
    wr(6'h26, 16'h0000);
    dip_position <= 4'h1;
    cyc(300);
    check({15'h0, comm_error}, 16'h0000);
    wr(6'h26, 16'h0002);
    dip_position <= 4'h0;
    cyc(40);
    check({15'h0, comm_error}, 16'h0000);
    dip_position <= 4'h1;
    repeat (8) begin
      slave_traffic <= 1'b1;
      @(negedge sys_clk);
      slave_traffic <= 1'b0;
      cyc(7);
    end
    check({15'h0, comm_error}, 16'h0000);
    cyc(40);
    check({15'h0, comm_error}, 16'h0001);
    $display("test watchdog done");
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // inputs idle at time zero, then the scenarios in order
  initial begin
    dip_position = 4'h0;
    channel_adopted = 1'b0;
    slave_found = 1'b0;
    slave_found_addr = 4'h0;
    rx_telegram = 1'b0;
    rx_network_id = 8'h00;
    slave_traffic = 1'b0;
    foreach (nvm[i]) nvm[i] = 16'h0000;
    nvm[32] = 16'h0005;
    nvm[38] = 16'h0014;
    do_reset();
    t_fixed();
    t_dip();
    t_lock();
    t_restart();
    t_scan_net();
    t_wdog();
    results();
  end
  // run needs under 2000 cycles; cut a hang at 10000
  initial begin
    #40000;
    fail_count++;
    results();
  end
endmodule
